/* File: common/atc_pkg.sv */
/*
 * Constants, field layouts and carrier types of the acquisition trigger
 * control block. It assumes a 32-bit AHB-Lite register bus and 16-bit
 * conversion data from a front end with up to 32 channels.
 */
package atc_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_START_CFG = 8'h04;
	localparam logic [7:0] OFS_STOP_CFG = 8'h08;
	localparam logic [7:0] OFS_START_LVL = 8'h0c;
	localparam logic [7:0] OFS_STOP_LVL = 8'h10;
	localparam logic [7:0] OFS_STOP_COUNT = 8'h14;
	localparam logic [7:0] OFS_DELAY_COUNT = 8'h18;
	localparam logic [7:0] OFS_REPEAT = 8'h1c;
	localparam logic [7:0] OFS_NOTIFY = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_SAMPLE_CNT = 8'h28;
	localparam logic [7:0] OFS_REPEAT_CNT = 8'h2c;
	// Control command bits (write-only pulses)
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	// Notify register: user buffer mode and ring format flags
	localparam int NOTIFY_USER_BIT = 31;
	localparam int NOTIFY_RING_BIT = 30;
	// Status bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_WAIT = 1;
	localparam int STAT_STORED = 2;
	localparam int STAT_OVF = 3;
	localparam int STAT_CLKERR = 4;
	localparam int STAT_CONVERR = 5;
	// Reset values
	localparam logic [31:0] RST_COUNT = 32'h0000_0000;
	localparam logic [31:0] RST_REPEAT = 32'h0000_0001;
	// ---------------------------------------------------------------
	// Source and comparison encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] SRC_SW = 3'h0;
	localparam logic [2:0] SRC_CMP = 3'h1;
	localparam logic [2:0] SRC_EXT = 3'h2;
	localparam logic [2:0] SRC_EVT = 3'h3;
	localparam logic [2:0] SRC_LAST = 3'h4;
	localparam logic [1:0] CMP_CROSS = 2'h0;
	localparam logic [1:0] CMP_IN = 2'h1;
	localparam logic [1:0] CMP_OUT = 2'h2;
	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	// Condition setup; low bits of the written word, src in the top field
	typedef struct packed {
		logic [2:0] src;
		logic [1:0] cmp;
		logic [1:0] dir;   // bit0 rising, bit1 falling
		logic pol;         // 0 rising edge, 1 falling edge
		logic [2:0] evt_sel;
		logic [4:0] chan;
	} atc_cond_t;
	typedef struct packed {
		logic [15:0] lvl2; // lower window bound
		logic [15:0] lvl1; // crossing level and upper window bound
	} atc_lvl_t;
	typedef struct packed {
		logic start_met;
		logic repeat_end;
		logic op_end;
		logic stored_cnt;
		logic xfer_cnt;
		logic overflow;
		logic clk_err;
		logic conv_err;
	} atc_evt_t;
	typedef struct packed {
		logic valid;
		logic [4:0] chan;
		logic [15:0] data;
	} atc_store_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_DELAY = 4'h8
	} atc_state_t;
endpackage : atc_pkg

/* File: core/atc_core.sv */
/*
 * Acquisition start/stop sequencer with its AHB-Lite register slave.
 * Assumes a synchronous conversion stream (one conversion per valid beat,
 * last beat of a sampling flagged) and synchronous trigger, event and
 * error inputs. Memory itself lies outside; this block only gates stores.
 */
// What this block does
// - Start source is software, data comparison, external edge or event output.
// - Start and stop setups are separate registers, freely combined.
// - Software start begins sampling and storing at the start command.
// - Comparison start watches one channel against level and direction before storing.
// - Crossing detects rising, falling, or either when both directions set.
// - In-range start fires when level2 <= value <= level1, even immediately.
// - Out-of-range start fires when value <= level2 or value >= level1.
// - External start arms at the command and fires on the chosen edge.
// - Event start waits for the selected event-controller output.
// - Stop sources: count, comparison, external, event, software; errors always halt.
// - Count stop halts after exactly the configured number of stored samplings.
// - Comparison stop halts on a crossing in the configured direction.
// - In-range stop fires when value lies in level2..level1 inclusive, even immediately.
// - Out-of-range stop fires when value <= level2 or >= level1.
// - External stop arms after the configured sample count, then halts on edge.
// - Software stop samples endlessly until stop command or error.
// - Event stop fires when the selected event output asserts.
// - Non-abort stops take the configured delayed samplings; zero stops at once.
// - Start-met event is raised, but never for software start.
// - Repeat-end after each repetition, operation-end after the whole operation.
// - Stored-count event in device buffer mode, transfer-count event in user mode.
// - Overflow, sample clock error and conversion error events.
// - Repetitions counted to the configured value; zero repeats until abort.
`timescale 1ns/1ps
`default_nettype none
module atc_core (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic CONV_VALID,
	input wire logic CONV_LAST,
	input wire logic [4:0] CONV_CHAN,
	input wire logic [15:0] CONV_DATA,
	input wire logic EXT_TRIG,
	input wire logic [7:0] EVT_IN,
	input wire logic MEM_FULL,
	input wire logic CLK_ERR,
	input wire logic CONV_ERR,
	output logic SAMPLE_EN,
	output logic BUSY,
	output logic WAITING,
	output atc_pkg::atc_store_t STORE,
	output atc_pkg::atc_evt_t EVT_OUT
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic ready;
		logic [31:0] rdata;
		logic wr_pend;
		logic [7:0] addr;
		atc_pkg::atc_cond_t start_cfg;
		atc_pkg::atc_cond_t stop_cfg;
		atc_pkg::atc_lvl_t start_lvl;
		atc_pkg::atc_lvl_t stop_lvl;
		logic [31:0] stop_count;
		logic [31:0] delay_count;
		logic [31:0] repeat_cfg;
		logic [31:0] notify;
		atc_pkg::atc_state_t state;
		logic [31:0] smp_cnt;
		logic [31:0] dly_cnt;
		logic [31:0] rep_cnt;
		logic [31:0] tot_cnt;
		logic [31:0] xfer_cnt;
		logic stop_pend;
		logic s_prev_ok;
		logic [15:0] s_prev;
		logic p_prev_ok;
		logic [15:0] p_prev;
		logic ext_prev;
		logic stored_flag;
		logic ovf_flag;
		logic clkerr_flag;
		logic converr_flag;
		logic sample_en;
		logic busy;
		logic waiting;
		atc_pkg::atc_store_t store;
		atc_pkg::atc_evt_t evt;
	} atc_regs_t;

	atc_regs_t q;
	atc_regs_t n;

	// Crossing against lvl1, or window tests against lvl2..lvl1
	function automatic logic cond_hit(input atc_pkg::atc_cond_t c, input atc_pkg::atc_lvl_t l,
		input logic prev_ok, input logic [15:0] prev, input logic [15:0] cur);
		logic up;
		logic down;
		up = prev_ok && (prev < l.lvl1) && (cur >= l.lvl1);
		down = prev_ok && (prev > l.lvl1) && (cur <= l.lvl1);
		case (c.cmp)
			atc_pkg::CMP_CROSS: cond_hit = (c.dir[0] && up) || (c.dir[1] && down);
			atc_pkg::CMP_IN: cond_hit = (cur >= l.lvl2) && (cur <= l.lvl1);
			atc_pkg::CMP_OUT: cond_hit = (cur <= l.lvl2) || (cur >= l.lvl1);
			default: cond_hit = 1'b0;
		endcase
	endfunction : cond_hit

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic start_cmd;
		logic stop_cmd;
		logic clr_cmd;
		logic mon_s;
		logic mon_p;
		logic start_hit;
		logic stop_hit;
		logic ext_edge_s;
		logic ext_edge_p;
		logic evt_s;
		logic evt_p;
		logic smp_done;
		logic storing;
		logic rep_done;
		logic go_wait;
		logic halt;
		logic [31:0] cnt_n;
		n = q;
		n.evt = '0;
		n.store = '0;
		start_cmd = 1'b0;
		stop_cmd = 1'b0;
		clr_cmd = 1'b0;
		rep_done = 1'b0;
		go_wait = 1'b0;
		halt = 1'b0;
		// Defaults keep every local defined on all paths
		mon_s = 1'b0;
		mon_p = 1'b0;
		start_hit = 1'b0;
		stop_hit = 1'b0;
		ext_edge_s = 1'b0;
		ext_edge_p = 1'b0;
		evt_s = 1'b0;
		evt_p = 1'b0;
		smp_done = 1'b0;
		storing = 1'b0;
		cnt_n = 32'h0000_0000;
		// Register writes land in the data phase
		if (q.wr_pend) begin
			case (q.addr)
				atc_pkg::OFS_CTRL: begin
					start_cmd = HWDATA[atc_pkg::CTRL_START_BIT];
					stop_cmd = HWDATA[atc_pkg::CTRL_STOP_BIT];
					clr_cmd = HWDATA[atc_pkg::CTRL_CLR_BIT];
				end
				atc_pkg::OFS_START_CFG: n.start_cfg = atc_pkg::atc_cond_t'(HWDATA[15:0]);
				atc_pkg::OFS_STOP_CFG: n.stop_cfg = atc_pkg::atc_cond_t'(HWDATA[15:0]);
				atc_pkg::OFS_START_LVL: n.start_lvl = HWDATA;
				atc_pkg::OFS_STOP_LVL: n.stop_lvl = HWDATA;
				atc_pkg::OFS_STOP_COUNT: n.stop_count = HWDATA;
				atc_pkg::OFS_DELAY_COUNT: n.delay_count = HWDATA;
				atc_pkg::OFS_REPEAT: n.repeat_cfg = HWDATA;
				atc_pkg::OFS_NOTIFY: n.notify = HWDATA;
				default: ;
			endcase
		end
		// Sampling-level views of the stream
		mon_s = CONV_VALID && (CONV_CHAN == q.start_cfg.chan);
		mon_p = CONV_VALID && (CONV_CHAN == q.stop_cfg.chan);
		start_hit = mon_s && cond_hit(q.start_cfg, q.start_lvl, q.s_prev_ok, q.s_prev, CONV_DATA);
		stop_hit = mon_p && cond_hit(q.stop_cfg, q.stop_lvl, q.p_prev_ok, q.p_prev, CONV_DATA);
		ext_edge_s = q.start_cfg.pol ? (q.ext_prev && !EXT_TRIG) : (!q.ext_prev && EXT_TRIG);
		ext_edge_p = q.stop_cfg.pol ? (q.ext_prev && !EXT_TRIG) : (!q.ext_prev && EXT_TRIG);
		evt_s = EVT_IN[q.start_cfg.evt_sel];
		evt_p = EVT_IN[q.stop_cfg.evt_sel];
		smp_done = CONV_VALID && CONV_LAST;
		cnt_n = q.smp_cnt + 32'h0000_0001;
		n.ext_prev = EXT_TRIG;
		if (mon_s) begin
			n.s_prev = CONV_DATA;
			n.s_prev_ok = 1'b1;
		end
		if (mon_p) begin
			n.p_prev = CONV_DATA;
			n.p_prev_ok = 1'b1;
		end
		// Sequencer
		case (q.state)
			atc_pkg::ST_IDLE: begin
				if (start_cmd) begin
					n.rep_cnt = atc_pkg::RST_COUNT;
					n.tot_cnt = atc_pkg::RST_COUNT;
					n.xfer_cnt = atc_pkg::RST_COUNT;
					n.stored_flag = 1'b0;
					go_wait = 1'b1;
				end
			end
			atc_pkg::ST_WAIT: begin
				case (q.start_cfg.src)
					atc_pkg::SRC_CMP: if (start_hit) n.state = atc_pkg::ST_RUN;
					atc_pkg::SRC_EXT: if (ext_edge_s) n.state = atc_pkg::ST_RUN;
					atc_pkg::SRC_EVT: if (evt_s) n.state = atc_pkg::ST_RUN;
					default: n.state = atc_pkg::ST_RUN;
				endcase
				n.evt.start_met = (n.state == atc_pkg::ST_RUN);
			end
			atc_pkg::ST_RUN: begin
				case (q.stop_cfg.src)
					atc_pkg::SRC_CMP: if (stop_hit) n.stop_pend = 1'b1;
					atc_pkg::SRC_EXT: if (ext_edge_p && q.smp_cnt >= q.stop_count)
						n.stop_pend = 1'b1;
					atc_pkg::SRC_EVT: if (evt_p) n.stop_pend = 1'b1;
					default: ;
				endcase
				if (smp_done) begin
					n.smp_cnt = cnt_n;
					if (n.stop_pend || (q.stop_cfg.src == atc_pkg::SRC_LAST
						&& cnt_n == q.stop_count)) begin
						n.stop_pend = 1'b0;
						n.dly_cnt = atc_pkg::RST_COUNT;
						if (q.delay_count == atc_pkg::RST_COUNT)
							rep_done = 1'b1;
						else
							n.state = atc_pkg::ST_DELAY;
					end
				end
			end
			atc_pkg::ST_DELAY: begin
				if (smp_done) begin
					n.dly_cnt = q.dly_cnt + 32'h0000_0001;
					if (n.dly_cnt == q.delay_count)
						rep_done = 1'b1;
				end
			end
			default: n.state = atc_pkg::ST_IDLE;
		endcase
		// Stores run from the triggering conversion through delayed samplings
		storing = (q.state == atc_pkg::ST_RUN) || (q.state == atc_pkg::ST_DELAY)
			|| (q.state == atc_pkg::ST_WAIT && n.state == atc_pkg::ST_RUN);
		if (storing && CONV_VALID) begin
			if (MEM_FULL) begin
				n.evt.overflow = 1'b1;
				n.ovf_flag = 1'b1;
				// FIFO format halts; ring format overwrites
				halt = !q.notify[atc_pkg::NOTIFY_RING_BIT];
			end
			n.store.valid = !MEM_FULL || q.notify[atc_pkg::NOTIFY_RING_BIT];
			n.store.chan = CONV_CHAN;
			n.store.data = CONV_DATA;
		end
		// Notification counts per stored sampling
		if (storing && smp_done) begin
			if (q.notify[atc_pkg::NOTIFY_USER_BIT]) begin
				n.xfer_cnt = q.xfer_cnt + 32'h0000_0001;
				if (n.xfer_cnt == {8'h00, q.notify[23:0]}) begin
					n.evt.xfer_cnt = 1'b1;
					n.xfer_cnt = atc_pkg::RST_COUNT;
				end
			end else begin
				n.tot_cnt = q.tot_cnt + 32'h0000_0001;
				if (n.tot_cnt == {8'h00, q.notify[23:0]}) begin
					n.evt.stored_cnt = 1'b1;
					n.stored_flag = 1'b1;
				end
			end
		end
		// Repetition bookkeeping
		if (rep_done) begin
			n.evt.repeat_end = 1'b1;
			n.rep_cnt = q.rep_cnt + 32'h0000_0001;
			if (q.repeat_cfg != atc_pkg::RST_COUNT && n.rep_cnt == q.repeat_cfg) begin
				n.evt.op_end = 1'b1;
				n.state = atc_pkg::ST_IDLE;
			end else begin
				go_wait = 1'b1;
			end
		end
		// Errors halt whatever the stop source; clear loses to a new error
		if (clr_cmd) begin
			n.clkerr_flag = 1'b0;
			n.converr_flag = 1'b0;
			n.ovf_flag = 1'b0;
		end
		if (q.state != atc_pkg::ST_IDLE) begin
			if (CLK_ERR) begin
				n.evt.clk_err = 1'b1;
				n.clkerr_flag = 1'b1;
				halt = 1'b1;
			end
			if (CONV_ERR) begin
				n.evt.conv_err = 1'b1;
				n.converr_flag = 1'b1;
				halt = 1'b1;
			end
			if (MEM_FULL && storing && CONV_VALID)
				n.ovf_flag = 1'b1;
		end
		// A fresh wait for the start condition, first or repeated
		if (go_wait) begin
			n.smp_cnt = atc_pkg::RST_COUNT;
			n.stop_pend = 1'b0;
			n.s_prev_ok = 1'b0;
			n.p_prev_ok = 1'b0;
			n.state = (q.start_cfg.src == atc_pkg::SRC_SW) ? atc_pkg::ST_RUN : atc_pkg::ST_WAIT;
		end
		// Abort skips delayed samplings and any further repetitions
		if ((stop_cmd || halt) && q.state != atc_pkg::ST_IDLE) begin
			n.state = atc_pkg::ST_IDLE;
			n.evt.op_end = 1'b1;
			n.evt.repeat_end = 1'b0;
		end
		// Front end converts while storing, or while a comparison waits
		n.sample_en = (n.state == atc_pkg::ST_RUN) || (n.state == atc_pkg::ST_DELAY)
			|| (n.state == atc_pkg::ST_WAIT && q.start_cfg.src == atc_pkg::SRC_CMP);
		// Status pins registered so they leave straight from flops
		n.busy = (n.state != atc_pkg::ST_IDLE);
		n.waiting = (n.state == atc_pkg::ST_WAIT);
		// Bus address phase; readback sees this cycle's write already
		n.ready = 1'b1;
		n.wr_pend = HSEL && HTRANS[1] && HREADY && HWRITE;
		if (HSEL && HTRANS[1] && HREADY)
			n.addr = HADDR[7:0];
		n.rdata = 32'h0000_0000;
		if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
			case (HADDR[7:0])
				atc_pkg::OFS_START_CFG: n.rdata = {16'h0000, n.start_cfg};
				atc_pkg::OFS_STOP_CFG: n.rdata = {16'h0000, n.stop_cfg};
				atc_pkg::OFS_START_LVL: n.rdata = n.start_lvl;
				atc_pkg::OFS_STOP_LVL: n.rdata = n.stop_lvl;
				atc_pkg::OFS_STOP_COUNT: n.rdata = n.stop_count;
				atc_pkg::OFS_DELAY_COUNT: n.rdata = n.delay_count;
				atc_pkg::OFS_REPEAT: n.rdata = n.repeat_cfg;
				atc_pkg::OFS_NOTIFY: n.rdata = n.notify;
				atc_pkg::OFS_STATUS: begin
					n.rdata[atc_pkg::STAT_BUSY] = (q.state != atc_pkg::ST_IDLE);
					n.rdata[atc_pkg::STAT_WAIT] = (q.state == atc_pkg::ST_WAIT);
					n.rdata[atc_pkg::STAT_STORED] = q.stored_flag;
					n.rdata[atc_pkg::STAT_OVF] = q.ovf_flag;
					n.rdata[atc_pkg::STAT_CLKERR] = q.clkerr_flag;
					n.rdata[atc_pkg::STAT_CONVERR] = q.converr_flag;
				end
				atc_pkg::OFS_SAMPLE_CNT: n.rdata = q.tot_cnt;
				atc_pkg::OFS_REPEAT_CNT: n.rdata = q.rep_cnt;
				default: n.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.state <= atc_pkg::ST_IDLE;
			q.repeat_cfg <= atc_pkg::RST_REPEAT;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from flops; HRESP tied low
	assign HRDATA = q.rdata;
	assign HREADYOUT = q.ready;
	assign HRESP = 1'b0;
	assign SAMPLE_EN = q.sample_en;
	assign BUSY = q.busy;
	assign WAITING = q.waiting;
	assign STORE = q.store;
	assign EVT_OUT = q.evt;
endmodule : atc_core
`default_nettype wire

/* File: tb/atc_core_sva.sv */
/* Port checker for the acquisition trigger sequencer.
   Assumes one clock domain and a bind onto atc_core. */
`timescale 1ns/1ps
`default_nettype none
module atc_core_sva (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CONV_VALID,
	input wire logic [4:0] CONV_CHAN,
	input wire logic [15:0] CONV_DATA,
	input wire logic CLK_ERR,
	input wire logic CONV_ERR,
	input wire logic BUSY,
	input wire logic WAITING,
	input wire atc_pkg::atc_store_t STORE,
	input wire atc_pkg::atc_evt_t EVT_OUT
);
	// ------------------
	// Timing properties
	// ------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Halt must follow an error within two edges
	sequence s_halt;
		##[1:2] !BUSY;
	endsequence
	AST_STORE_DATA: assert property (STORE.valid |-> $past(CONV_VALID) && STORE.data == $past(CONV_DATA))
		else $error("store without its conversion");
	AST_STORE_CHAN: assert property (STORE.valid |-> STORE.chan == $past(CONV_CHAN))
		else $error("store channel wrong");
	AST_IDLE_QUIET: assert property (!$past(BUSY) |-> !STORE.valid)
		else $error("store while idle");
	AST_WAIT_NO_STORE: assert property (WAITING && $past(WAITING) |-> !STORE.valid)
		else $error("store while still waiting");
	AST_OPEND_PULSE: assert property (EVT_OUT.op_end |=> !EVT_OUT.op_end)
		else $error("end event longer than a cycle");
	AST_END_EVT: assert property ($fell(BUSY) |-> ##[0:1] EVT_OUT.op_end)
		else $error("operation ended without end event");
	AST_CONV_ERR: assert property (CONV_ERR && BUSY |=> EVT_OUT.conv_err)
		else $error("conversion error event missing");
	AST_CLK_ERR: assert property (CLK_ERR && BUSY |=> EVT_OUT.clk_err)
		else $error("clock error event missing");
	AST_ERR_HALT: assert property ((CONV_ERR || CLK_ERR) && BUSY |-> s_halt)
		else $error("error did not halt sampling");
	AST_START_MET: assert property ($rose(EVT_OUT.start_met) |-> $past(WAITING) || $past(WAITING, 2))
		else $error("start event without a wait");
endmodule : atc_core_sva
bind atc_core atc_core_sva u_sva (.CLK(CLK), .RST(RST), .CONV_VALID(CONV_VALID),
	.CONV_CHAN(CONV_CHAN), .CONV_DATA(CONV_DATA), .CLK_ERR(CLK_ERR), .CONV_ERR(CONV_ERR),
	.BUSY(BUSY), .WAITING(WAITING), .STORE(STORE), .EVT_OUT(EVT_OUT));
`default_nettype wire

/* File: tb/atc_fe_model.sv */
/* Front end and trigger source model: two channels a sampling.
   Assumes SAMPLE_EN from the sequencer and a trigger level from the bench. */
`timescale 1ns/1ps
`default_nettype none
module atc_fe_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic sample_en,
	input wire logic trig_lvl,
	output logic conv_valid,
	output logic conv_last,
	output logic [4:0] conv_chan,
	output logic [15:0] conv_data,
	output logic ext_trig
);
	// ---------------
	// Conversion beat
	// ---------------
	logic [1:0] ph;
	logic [7:0] smp;
	// Ch0 ramps by 0x100 a sampling, ch1 fixed; idle data toggles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph <= 2'h0;
			smp <= 8'h00;
			conv_valid <= 1'b0;
			conv_last <= 1'b0;
			conv_chan <= 5'h00;
			conv_data <= 16'h0000;
		end else begin
			ph <= sample_en ? ph + 2'h1 : 2'h0;
			conv_valid <= sample_en && !ph[1];
			conv_last <= sample_en && ph == 2'h1;
			conv_chan <= {4'h0, ph[0]};
			conv_data <= !sample_en || ph[1] ? ~conv_data : ph[0] ? 16'h5555 : {smp, 8'h00};
			smp <= !sample_en ? 8'h00 : smp + {7'h00, ph == 2'h1};
		end
	end
	// Edge source: the bench steps the level between frames
	assign ext_trig = trig_lvl;
endmodule : atc_fe_model
`default_nettype wire

/* File: tb/tb.sv */
/* Self-checking bench for atc_core over AHB-Lite.
   Assumes the front end model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, hsel, hwrite, trig, clk_err, conv_err, rdy_q, mem_full;
	logic hreadyout, hresp, sample_en, busy, waiting, cv, cl, ext;
	logic [31:0] haddr, hwdata, hrdata, hr_q, v;
	logic [1:0] htrans;
	logic [7:0] evt_in;
	logic [4:0] cc;
	logic [15:0] cd, first_q;
	atc_pkg::atc_store_t store;
	atc_pkg::atc_evt_t evt_out;
	int n_errors, comparisons, n_st, n_sm, n_re, n_oe, n_sc;
	logic [1:0] tc [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
	logic [1:0] td [4] = '{2'h1, 2'h3, 2'h0, 2'h0};
	logic [31:0] tl [4] = '{32'h0280, 32'h0280, 32'h0200_02ff, 32'h0100_0300};
	logic [15:0] tx [4] = '{16'h0300, 16'h0300, 16'h0200, 16'h0000};
	atc_core dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .CONV_VALID(cv), .CONV_LAST(cl),
		.CONV_CHAN(cc), .CONV_DATA(cd), .EXT_TRIG(ext), .EVT_IN(evt_in), .MEM_FULL(mem_full),
		.CLK_ERR(clk_err), .CONV_ERR(conv_err), .SAMPLE_EN(sample_en), .BUSY(busy),
		.WAITING(waiting), .STORE(store), .EVT_OUT(evt_out));
	atc_fe_model fe (.clk(clk), .rst(rst), .sample_en(sample_en), .trig_lvl(trig),
		.conv_valid(cv), .conv_last(cl), .conv_chan(cc), .conv_data(cd), .ext_trig(ext));
	// ----------------
	// Bus and checking
	// ----------------
	// Edge samples of the slave answer, free of update races
	always @(posedge clk) begin
		rdy_q <= hreadyout;
		hr_q <= hrdata;
		if (store.valid === 1'b1) begin
			if (n_st == 0) first_q <= store.data;
			n_st <= n_st + 1;
		end
		n_sm <= n_sm + int'(evt_out.start_met === 1'b1);
		n_re <= n_re + int'(evt_out.repeat_end === 1'b1);
		n_oe <= n_oe + int'(evt_out.op_end === 1'b1);
		n_sc <= n_sc + int'(evt_out.stored_cnt === 1'b1 || evt_out.xfer_cnt === 1'b1);
	end
	task automatic rdy;
		do begin
			@(posedge clk);
			#1;
		end while (rdy_q !== 1'b1);
	endtask : rdy
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy;
		v = hr_q;
	endtask : xfer
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] cf(logic [2:0] s, logic [1:0] c, logic [1:0] d);
		cf = {16'h0, s, c, d, 1'b0, 3'h3, 5'h00};
	endfunction : cf
	// Configure both conditions, clear tallies, issue start
	task automatic run(input logic [31:0] sc, input logic [31:0] pc, input logic [31:0] n, dl);
		xfer(1, atc_pkg::OFS_START_CFG, sc);
		xfer(1, atc_pkg::OFS_STOP_CFG, pc);
		xfer(1, atc_pkg::OFS_STOP_COUNT, n);
		xfer(1, atc_pkg::OFS_DELAY_COUNT, dl);
		{n_st, n_sm, n_re, n_oe, n_sc} = '0;
		xfer(1, atc_pkg::OFS_CTRL, 32'h1);
	endtask : run
	task automatic idle;
		while (busy !== 1'b0) begin
			@(posedge clk);
			#1;
		end
		repeat (3) @(posedge clk);
		#1;
	endtask : idle
	task automatic complete_run;
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		complete_run;
	end
	// Test sequence
	initial begin
		{rst, hsel, hwrite, trig, clk_err, conv_err, mem_full} = 7'h40;
		{haddr, hwdata, htrans, evt_in} = '0;
		{n_errors, comparisons, n_st, n_sm, n_re, n_oe, n_sc} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		xfer(0, atc_pkg::OFS_REPEAT, 0); chk(v, 32'h1);
		xfer(0, 8'h30, 0); chk(v, 32'h0);
		chk(hresp, 1'b0);
		xfer(1, atc_pkg::OFS_START_CFG, 32'h1234);
		xfer(1, atc_pkg::OFS_STOP_CFG, 32'h8765);
		xfer(0, atc_pkg::OFS_START_CFG, 0); chk(v, 32'h1234);
		xfer(0, atc_pkg::OFS_STOP_CFG, 0); chk(v, 32'h8765);
		$display("test registers done");
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_LAST, 0, 0), 3, 0);
		idle;
		chk(n_st, 6);
		chk(n_sm, 0);
		chk(n_oe, 1);
		xfer(1, atc_pkg::OFS_REPEAT, 2);
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_LAST, 0, 0), 2, 2);
		idle;
		chk(n_st, 16);
		chk(n_re, 2);
		chk(n_oe, 1);
		xfer(1, atc_pkg::OFS_REPEAT, 1);
		$display("test software start done");
		for (int i = 0; i < 4; i++) begin
			xfer(1, atc_pkg::OFS_START_LVL, tl[i]);
			run(cf(atc_pkg::SRC_CMP, tc[i], td[i]), cf(atc_pkg::SRC_LAST, 0, 0), 2, 0);
			idle;
			chk(first_q, tx[i]);
			chk(n_st, 4);
			chk(n_sm, 1);
		end
		$display("test compare start done");
		for (int k = 0; k < 2; k++) begin
			run(cf(k ? atc_pkg::SRC_EVT : atc_pkg::SRC_EXT, 0, 0), cf(atc_pkg::SRC_LAST, 0, 0), 1, 0);
			repeat (20) @(posedge clk);
			#1;
			chk(waiting, 1'b1);
			chk(n_st, 0);
			chk(sample_en, 1'b0);
			if (k == 0) trig <= 1'b1;
			else evt_in <= 8'h08;
			idle;
			chk(n_sm, 1);
			chk(n_st, 2);
			trig <= 1'b0;
			evt_in <= 8'h00;
		end
		$display("test trigger start done");
		// Comparison stops under a software start; the hit sampling closes the run
		for (int i = 1; i < 4; i++) begin
			xfer(1, atc_pkg::OFS_STOP_LVL, tl[i]);
			run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_CMP, tc[i], td[i]), 0, 0);
			idle;
			chk(n_st, i == 1 ? 8 : i == 2 ? 6 : 2);
			chk(n_re, 1);
		end
		// Early edge must be ignored until two samplings are stored
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_EXT, 0, 0), 2, 0);
		trig <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk(busy, 1'b1);
		trig <= 1'b0;
		repeat (2) @(posedge clk);
		trig <= 1'b1;
		idle;
		chk(n_re, 1);
		trig <= 1'b0;
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_EVT, 0, 0), 0, 0);
		repeat (20) @(posedge clk);
		#1;
		chk(busy, 1'b1);
		evt_in <= 8'h08;
		idle;
		chk(n_re, 1);
		evt_in <= 8'h00;
		$display("test stop sources done");
		// Stored-count in device mode, transfer-count each sampling in user mode
		xfer(1, atc_pkg::OFS_NOTIFY, 32'h2);
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_LAST, 0, 0), 3, 0);
		idle;
		chk(n_sc, 1);
		xfer(0, atc_pkg::OFS_STATUS, 0); chk(v & 32'h4, 32'h4);
		xfer(1, atc_pkg::OFS_NOTIFY, 32'h8000_0001);
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_LAST, 0, 0), 3, 0);
		idle;
		chk(n_sc, 3);
		// Full FIFO memory halts the run with no repeat end
		xfer(1, atc_pkg::OFS_NOTIFY, 32'h0);
		run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_SW, 0, 0), 0, 0);
		repeat (10) @(posedge clk);
		mem_full <= 1'b1;
		idle;
		mem_full <= 1'b0;
		chk(n_oe, 1);
		chk(n_re, 0);
		xfer(0, atc_pkg::OFS_STATUS, 0); chk(v & 32'h8, 32'h8);
		$display("test notify and overflow done");
		for (int e = 0; e < 3; e++) begin
			run(cf(atc_pkg::SRC_SW, 0, 0), cf(atc_pkg::SRC_SW, 0, 0), 0, 0);
			repeat (30) @(posedge clk);
			#1;
			if (e == 0) xfer(1, atc_pkg::OFS_CTRL, 32'h2);
			else if (e == 1) conv_err <= 1'b1;
			else clk_err <= 1'b1;
			@(posedge clk);
			{conv_err, clk_err} <= 2'h0;
			idle;
			chk(n_oe, 1);
			chk(n_re, 0);
			xfer(0, atc_pkg::OFS_STATUS, 0); chk(v & 32'h31, e == 1 ? 32'h20 : e == 2 ? 32'h10 : 0);
			xfer(1, atc_pkg::OFS_CTRL, 32'h4);
			xfer(0, atc_pkg::OFS_STATUS, 0); chk(v & 32'h30, 32'h0);
		end
		$display("test stop and errors done");
		complete_run;
	end
endmodule : tb
`default_nettype wire
